/* File: testbench/scid_assertions.sv */
// port-level assertions for the scan instruction decoder
`timescale 1ns/1ps
`default_nettype none
`include "scid_regs.vh"
module scid_chk (
   input wire clk,
   input wire srst,
   input wire [`SCID_BSR_W-1:0] bnd_drive_q,
   input wire test_mode_q,
   input wire highz_q,
   input wire bnd_drive_en_q,
   input wire [1:0] dr_sel_q,
   input wire run_active_q,
   input wire [2:0] run_op_q
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   sequence s_release;
      $fell(srst);
   endsequence
   // clamp, toggle-only or run test outside idle: bypass in test mode, no run operation
   sequence s_cells_frozen;
      test_mode_q && !highz_q && dr_sel_q == `SCID_DR_BYP && !run_active_q;
   endsequence
   a_reset_id_sel: assert property (s_release |-> dr_sel_q == `SCID_DR_ID
      && !test_mode_q && bnd_drive_q == `SCID_BSR_RESET)
      else $error("reset state wrong");
   a_highz_float: assert property (highz_q |-> test_mode_q && !bnd_drive_en_q)
      else $error("highz outside modified test mode");
   a_drive_in_test: assert property (bnd_drive_en_q |-> test_mode_q)
      else $error("cells drive in normal mode");
   a_id_normal: assert property (dr_sel_q == `SCID_DR_ID |-> !test_mode_q)
      else $error("id register selected in test mode");
   a_run_bypass_test: assert property (run_active_q |-> test_mode_q && !dr_sel_q)
      else $error("run operation outside bypass test mode");
   a_run_op_legal: assert property (run_active_q |-> !run_op_q[2] || &run_op_q)
      else $error("illegal run operation code");
   a_shadow_cause: assert property ($changed(bnd_drive_q) |-> dr_sel_q == `SCID_DR_BSR
      || test_mode_q && dr_sel_q == `SCID_DR_BYP || bnd_drive_q == `SCID_BSR_RESET)
      else $error("boundary shadows changed without cause");
   a_inputs_hold: assert property (s_cells_frozen ##1 s_cells_frozen |-> $stable(bnd_drive_q & `SCID_BSR_IN_MASK))
      else $error("input cells moved while frozen");
endmodule
`default_nettype wire

/* File: testbench/scid_ctl_model.sv */
// scan test controller model driving tck, tms and tdi
`timescale 1ns/1ps
`default_nettype none
module scid_ctl_model (
   input wire logic clk,
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo
);
   logic q;
   initial {tck, tms, tdi} = 3'b010;
   // tms and tdi move with the fall; tdo is read at the last clk edge of the high phase
   task automatic step(input logic m, input logic d);
      tms <= m;
      tdi <= d;
      repeat (4) @(posedge clk);
      tck <= 1'b1;
      repeat (4) @(posedge clk);
      q = tdo;
      tck <= 1'b0;
   endtask
   // tdi toggles outside shifting so a stale level is never mistaken for data
   task automatic idle(input int k);
      repeat (k) step(1'b0, ~tdi);
      // step off the closing clk edge before the caller looks at outputs
      #1;
   endtask
   // from idle through one ir or dr scan back to idle, lsb first
   task automatic scan(input logic ir, input int n, input logic [83:0] din,
      output logic [83:0] dout);
      dout = '0;
      step(1'b1, ~tdi);
      if (ir)
         step(1'b1, ~tdi);
      step(1'b0, ~tdi);
      step(1'b0, ~tdi);
      for (int i = 0; i < n; i++)
      begin
         step(i == n - 1, din[i]);
         dout[i] = q;
      end
      step(1'b1, ~tdi);
      step(1'b0, ~tdi);
      #1;
   endtask
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the scan instruction decoder
`timescale 1ns/1ps
`default_nettype none
`include "scid_regs.vh"
module testbench;
   localparam logic [31:0] ID = 32'h2468ace1; // arbitrary identification value
   logic clk = 1'b0, srst = 1'b1;
   logic [83:0] bnd_sense = '0;
   logic [83:0] pat, mo, got;
   logic [31:0] rs = 32'h1d;
   logic [7:0] op;
   int err_total = 0;
   int total_checks = 0;
   int oe_clk = 0;
   int oe0;
   wire tck, tms, tdi, tdo_q, tdo_oe_q, test_mode_q, highz_q, bnd_drive_en_q, run_active_q;
   wire [83:0] bnd_drive_q;
   wire [1:0] dr_sel_q;
   wire [2:0] run_op_q;
   always #5 clk = ~clk;
   // clk cycles with the serial output enabled
   always @(posedge clk)
   begin
      if (tdo_oe_q)
         oe_clk <= oe_clk + 1;
   end
   scid_ctl_model u_ctl (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_q));
   scid_top #(.ID_VALUE(ID)) DUT (
      .clk(clk),
      .srst(srst),
      .tck(tck),
      .tms(tms),
      .tdi(tdi),
      .bnd_sense(bnd_sense),
      .tdo_q(tdo_q),
      .tdo_oe_q(tdo_oe_q),
      .bnd_drive_q(bnd_drive_q),
      .test_mode_q(test_mode_q),
      .highz_q(highz_q),
      .bnd_drive_en_q(bnd_drive_en_q),
      .dr_sel_q(dr_sel_q),
      .run_active_q(run_active_q),
      .run_op_q(run_op_q)
   );
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   // expected data register and test mode of an opcode
   function automatic logic [1:0] sel(input logic [7:0] o);
      case (o)
         8'h00, 8'h03, 8'h82, 8'h0a, 8'h8b, 8'h0c: return 2'h1;
         8'h81: return 2'h2;
         8'h8e, 8'h0f: return 2'h3;
         default: return 2'h0;
      endcase
   endfunction
   function automatic logic tst(input logic [7:0] o);
      return o inside {8'h00, 8'h03, 8'h06, 8'h87, 8'h09, 8'h8b, 8'h8d, 8'h0f};
   endfunction
   task automatic chk(input logic [83:0] seen, input logic [83:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic rnd(output logic [83:0] r);
      repeat (3)
      begin
         rs = xs(rs);
         r = {r[51:0], rs};
      end
   endtask
   task automatic ir(input logic [7:0] o);
      u_ctl.scan(1'b1, 8, {76'h0, o}, got);
      chk(got[7:0], 8'h01);
   endtask
   initial
   begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      #3;
      chk(dr_sel_q, 2'h2);
      chk(bnd_drive_q, `SCID_BSR_RESET);
      u_ctl.idle(1);
      oe0 = oe_clk;
      u_ctl.scan(1'b0, 32, '0, got);
      chk(got[31:0], ID);
      // enable stands for 32 link periods of 8 clk each
      chk(84'(oe_clk - oe0), 84'h100);
      // every listed opcode except ff first, then random bytes
      for (int i = 0; i < 24; i++)
      begin
         rs = xs(rs);
         op = i < 16 ? {^i[6:0], i[6:0]} : rs[7:0];
         ir(op);
         chk({dr_sel_q, test_mode_q, highz_q, bnd_drive_en_q},
            {sel(op), tst(op), op == 8'h06, tst(op) && op != 8'h06});
         u_ctl.scan(1'b0, 2, 84'h1, got);
         if (sel(op) == 2'h0)
            chk(got[1:0], 2'h2);
      end
      rnd(pat);
      rnd(mo);
      @(posedge clk);
      bnd_sense <= pat;
      #3;
      ir(8'h82);
      u_ctl.scan(1'b0, 84, mo, got);
      chk(got, pat);
      chk(bnd_drive_q, mo);
      ir(8'h0a);
      u_ctl.scan(1'b0, 84, pat, got);
      chk(got, mo);
      ir(8'h0c);
      u_ctl.scan(1'b0, 84, mo, got);
      chk(got, ~pat);
      ir(8'h8d);
      u_ctl.idle(3);
      #60;
      chk(bnd_drive_q, mo ^ ~`SCID_BSR_IN_MASK);
      u_ctl.idle(1);
      #60;
      chk(bnd_drive_q, mo);
      for (int i = 0; i < 8; i++)
      begin
         rnd(pat);
         pat[2:0] = i[2:0];
         ir(i[0] ? 8'h0f : 8'h8e);
         u_ctl.scan(1'b0, 21, pat, got);
         if (i > 0)
            chk(got[20:0], mo[20:0]);
         mo = pat;
         ir(8'h09);
         #60;
         op = {5'h1, i[1:0] == 2'h3 ? i[2] : 1'b0, i[1:0]};
         chk({run_active_q, run_op_q}, op[3:0]);
      end
      // five high tms steps reach test-logic-reset from any state
      repeat (5) u_ctl.step(1'b1, 1'b0);
      #3;
      chk({dr_sel_q, test_mode_q, run_active_q}, {2'h2, 1'b0, 1'b0});
      chk(bnd_drive_q, `SCID_BSR_RESET);
      end_of_test();
   end
endmodule
bind scid_top scid_chk u_chk (
   .clk(clk),
   .srst(srst),
   .bnd_drive_q(bnd_drive_q),
   .test_mode_q(test_mode_q),
   .highz_q(highz_q),
   .bnd_drive_en_q(bnd_drive_en_q),
   .dr_sel_q(dr_sel_q),
   .run_active_q(run_active_q),
   .run_op_q(run_op_q)
);
`default_nettype wire

/* File: verilog/scid_regs.vh */
// constants for the scan instruction decoder
`ifndef SCID_REGS_VH
`define SCID_REGS_VH

// register lengths
`define SCID_IR_W 8
`define SCID_BSR_W 84
`define SCID_BCR_W 21
`define SCID_ID_W 32

// instruction opcodes, bit 7 keeps even parity
`define SCID_OP_EXTEST 8'h00
`define SCID_OP_IDCODE 8'h81
`define SCID_OP_SAMPLE 8'h82
`define SCID_OP_INTEST 8'h03
`define SCID_OP_BYP_A 8'h84
`define SCID_OP_BYP_B 8'h05
`define SCID_OP_HIGHZ 8'h06
`define SCID_OP_CLAMP 8'h87
`define SCID_OP_BYP_C 8'h88
`define SCID_OP_RUN_BOUNDARY_TEST 8'h09
`define SCID_OP_RD_NORM 8'h0a
`define SCID_OP_RD_TEST 8'h8b
`define SCID_OP_CELL_CHK 8'h0c
`define SCID_OP_TOGGLE 8'h8d
`define SCID_OP_CTL_NORM 8'h8e
`define SCID_OP_CTL_TEST 8'h0f
`define SCID_OP_BYPASS 8'hff

// value loaded into the instruction shifter at capture
`define SCID_IR_CAPTURE 8'h01

// data register selection
`define SCID_DR_BYP 2'h0
`define SCID_DR_BSR 2'h1
`define SCID_DR_ID 2'h2
`define SCID_DR_BCR 2'h3

// operating mode
`define SCID_MODE_NORMAL 2'h0
`define SCID_MODE_TEST 2'h1
`define SCID_MODE_MOD_TEST 2'h2

// run-test operation field position and codes
`define SCID_BCR_OP_MSB 2
`define SCID_BCR_OP_LSB 0
`define SCID_RUN_TOGGLE 2'h0
`define SCID_RUN_PRPG36 2'h1
`define SCID_RUN_PSA36 2'h2
`define SCID_RUN_PSA_PRPG18 3'h3
`define SCID_RUN_PSA_COUNT18 3'h7

// reset values and input cell mask
`define SCID_BSR_RESET 84'hf00000000000000000000
`define SCID_BCR_RESET 21'h0
`define SCID_BSR_IN_MASK 84'hfffffffc0000ffffc0000

// tap controller states
`define SCID_ST_RESET 4'h0
`define SCID_ST_IDLE 4'h1
`define SCID_ST_SEL_DR 4'h2
`define SCID_ST_CAP_DR 4'h3
`define SCID_ST_SHIFT_DR 4'h4
`define SCID_ST_EXIT1_DR 4'h5
`define SCID_ST_PAUSE_DR 4'h6
`define SCID_ST_EXIT2_DR 4'h7
`define SCID_ST_UPD_DR 4'h8
`define SCID_ST_SEL_IR 4'h9
`define SCID_ST_CAP_IR 4'ha
`define SCID_ST_SHIFT_IR 4'hb
`define SCID_ST_EXIT1_IR 4'hc
`define SCID_ST_PAUSE_IR 4'hd
`define SCID_ST_EXIT2_IR 4'he
`define SCID_ST_UPD_IR 4'hf

`endif

/* File: verilog/scid_tap.v */
// sixteen-state test access port controller
`timescale 1ns/1ps
`default_nettype none
`include "scid_regs.vh"
module scid_tap (
   input wire clk,
   input wire srst,
   input wire tck_rise,
   input wire tms_s,
   output reg [3:0] state_q
);
   reg [3:0] state_d;

   always @*
   begin
      state_d = state_q;
      case (state_q)
         `SCID_ST_RESET: state_d = tms_s ? `SCID_ST_RESET : `SCID_ST_IDLE;
         `SCID_ST_IDLE: state_d = tms_s ? `SCID_ST_SEL_DR : `SCID_ST_IDLE;
         `SCID_ST_SEL_DR: state_d = tms_s ? `SCID_ST_SEL_IR : `SCID_ST_CAP_DR;
         `SCID_ST_CAP_DR: state_d = tms_s ? `SCID_ST_EXIT1_DR : `SCID_ST_SHIFT_DR;
         `SCID_ST_SHIFT_DR: state_d = tms_s ? `SCID_ST_EXIT1_DR : `SCID_ST_SHIFT_DR;
         `SCID_ST_EXIT1_DR: state_d = tms_s ? `SCID_ST_UPD_DR : `SCID_ST_PAUSE_DR;
         `SCID_ST_PAUSE_DR: state_d = tms_s ? `SCID_ST_EXIT2_DR : `SCID_ST_PAUSE_DR;
         `SCID_ST_EXIT2_DR: state_d = tms_s ? `SCID_ST_UPD_DR : `SCID_ST_SHIFT_DR;
         `SCID_ST_UPD_DR: state_d = tms_s ? `SCID_ST_SEL_DR : `SCID_ST_IDLE;
         `SCID_ST_SEL_IR: state_d = tms_s ? `SCID_ST_RESET : `SCID_ST_CAP_IR;
         `SCID_ST_CAP_IR: state_d = tms_s ? `SCID_ST_EXIT1_IR : `SCID_ST_SHIFT_IR;
         `SCID_ST_SHIFT_IR: state_d = tms_s ? `SCID_ST_EXIT1_IR : `SCID_ST_SHIFT_IR;
         `SCID_ST_EXIT1_IR: state_d = tms_s ? `SCID_ST_UPD_IR : `SCID_ST_PAUSE_IR;
         `SCID_ST_PAUSE_IR: state_d = tms_s ? `SCID_ST_EXIT2_IR : `SCID_ST_PAUSE_IR;
         `SCID_ST_EXIT2_IR: state_d = tms_s ? `SCID_ST_UPD_IR : `SCID_ST_SHIFT_IR;
         `SCID_ST_UPD_IR: state_d = tms_s ? `SCID_ST_SEL_DR : `SCID_ST_IDLE;
         default: state_d = `SCID_ST_RESET;
      endcase
   end

   always @(posedge clk)
   begin
      if (srst)
         state_q <= `SCID_ST_RESET;
      else if (tck_rise)
         state_q <= state_d;
   end
endmodule
`default_nettype wire

/* File: verilog/scid_top.v */
// scan instruction decoder with its data registers
// Summary of operation
// - eight-bit instructions, bit 7 gives even parity
// - 00 and 03 select boundary register, test
// - boundary cells capture sense, drive from shadows
// - 81 selects identification register, normal mode
// - unsupported and unlisted opcodes act as bypass
// - bypass: one bit, captures zero, normal
// - sample/preload captures boundary, normal operation continues
// - highz: bypass, pins float, logic keeps running
// - clamp: bypass, cells drive logic and pins
// - run test: bypass, test, operate in idle
// - boundary read keeps contents at capture
// - cell self check captures inverted shadow values
// - toggle outputs: output cells invert in idle
// - during toggle, input cells hold, no capture
// - control scans select control register, no capture
// - run operation from control bits 2..0
// - codes 011 and 111 select 18-bit combined operations
// - control register is 21 bits, lsb first
// - boundary register is 84 cells, 83..0
// - identification register 32 bits, loaded at capture
`timescale 1ns/1ps
`default_nettype none
`include "scid_regs.vh"
module scid_top #(
   // identification value is arbitrary, bit 0 must be one
   parameter [31:0] ID_VALUE = 32'h10001001
) (
   input wire clk,
   input wire srst,
   input wire tck,
   input wire tms,
   input wire tdi,
   input wire [`SCID_BSR_W-1:0] bnd_sense,
   output reg tdo_q,
   output reg tdo_oe_q,
   output reg [`SCID_BSR_W-1:0] bnd_drive_q,
   output reg test_mode_q,
   output reg highz_q,
   output reg bnd_drive_en_q,
   output reg [1:0] dr_sel_q,
   output reg run_active_q,
   output reg [2:0] run_op_q
);
   // decode: {dr select, mode}
   function [3:0] scid_decode;
      input [7:0] op;
      begin
         case (op)
            `SCID_OP_EXTEST, `SCID_OP_INTEST: scid_decode = {`SCID_DR_BSR, `SCID_MODE_TEST};
            `SCID_OP_IDCODE: scid_decode = {`SCID_DR_ID, `SCID_MODE_NORMAL};
            `SCID_OP_SAMPLE: scid_decode = {`SCID_DR_BSR, `SCID_MODE_NORMAL};
            `SCID_OP_HIGHZ: scid_decode = {`SCID_DR_BYP, `SCID_MODE_MOD_TEST};
            `SCID_OP_CLAMP: scid_decode = {`SCID_DR_BYP, `SCID_MODE_TEST};
            `SCID_OP_RUN_BOUNDARY_TEST: scid_decode = {`SCID_DR_BYP, `SCID_MODE_TEST};
            `SCID_OP_RD_NORM: scid_decode = {`SCID_DR_BSR, `SCID_MODE_NORMAL};
            `SCID_OP_RD_TEST: scid_decode = {`SCID_DR_BSR, `SCID_MODE_TEST};
            `SCID_OP_CELL_CHK: scid_decode = {`SCID_DR_BSR, `SCID_MODE_NORMAL};
            `SCID_OP_TOGGLE: scid_decode = {`SCID_DR_BYP, `SCID_MODE_TEST};
            `SCID_OP_CTL_NORM: scid_decode = {`SCID_DR_BCR, `SCID_MODE_NORMAL};
            `SCID_OP_CTL_TEST: scid_decode = {`SCID_DR_BCR, `SCID_MODE_TEST};
            // bad parity, unsupported or unlisted opcodes fall here
            default: scid_decode = {`SCID_DR_BYP, `SCID_MODE_NORMAL};
         endcase
      end
   endfunction

   // two-flop synchronisers for the link pins
   reg tck_m_q;
   reg tck_s_q;
   reg tck_prev_q;
   reg tms_m_q;
   reg tms_s_q;
   reg tdi_m_q;
   reg tdi_s_q;
   reg [`SCID_BSR_W-1:0] sense_m_q;
   reg [`SCID_BSR_W-1:0] sense_s_q;

   always @(posedge clk)
   begin
      if (srst)
      begin
         tck_m_q <= 1'b0;
         tck_s_q <= 1'b0;
         tck_prev_q <= 1'b0;
         tms_m_q <= 1'b1;
         tms_s_q <= 1'b1;
         tdi_m_q <= 1'b0;
         tdi_s_q <= 1'b0;
         sense_m_q <= {`SCID_BSR_W{1'b0}};
         sense_s_q <= {`SCID_BSR_W{1'b0}};
      end
      else
      begin
         tck_m_q <= tck;
         tck_s_q <= tck_m_q;
         tck_prev_q <= tck_s_q;
         tms_m_q <= tms;
         tms_s_q <= tms_m_q;
         tdi_m_q <= tdi;
         tdi_s_q <= tdi_m_q;
         sense_m_q <= bnd_sense;
         sense_s_q <= sense_m_q;
      end
   end

   wire tck_rise;
   wire tck_fall;
   assign tck_rise = tck_s_q & ~tck_prev_q;
   assign tck_fall = ~tck_s_q & tck_prev_q;

   wire [3:0] state;
   scid_tap u_tap (
      .clk(clk),
      .srst(srst),
      .tck_rise(tck_rise),
      .tms_s(tms_s_q),
      .state_q(state)
   );

   reg [`SCID_IR_W-1:0] ir_q;
   reg [`SCID_IR_W-1:0] ir_sh_q;
   reg byp_q;
   reg [`SCID_ID_W-1:0] id_sh_q;
   reg [`SCID_BCR_W-1:0] bcr_q;
   reg [`SCID_BSR_W-1:0] bsr_q;
   reg [`SCID_BSR_W-1:0] bsr_upd_q;

   wire [3:0] dec;
   wire [1:0] sel;
   wire [1:0] mode;
   wire [`SCID_BSR_W-1:0] in_mask;
   wire [`SCID_BSR_W-1:0] out_mask;
   wire [2:0] bcr_op;
   wire run_toggle;
   wire tog_only;
   wire in_idle;
   reg dr_out;

   assign dec = scid_decode(ir_q);
   assign sel = dec[3:2];
   assign mode = dec[1:0];
   assign in_mask = `SCID_BSR_IN_MASK;
   assign out_mask = ~in_mask;
   assign bcr_op = bcr_q[`SCID_BCR_OP_MSB:`SCID_BCR_OP_LSB];
   assign in_idle = (state == `SCID_ST_IDLE);
   assign tog_only = (ir_q == `SCID_OP_TOGGLE);
   assign run_toggle = (ir_q == `SCID_OP_RUN_BOUNDARY_TEST) && (bcr_op[1:0] == `SCID_RUN_TOGGLE);

   always @*
   begin
      case (sel)
         `SCID_DR_BSR: dr_out = bsr_q[0];
         `SCID_DR_ID: dr_out = id_sh_q[0];
         `SCID_DR_BCR: dr_out = bcr_q[0];
         default: dr_out = byp_q;
      endcase
   end

   // scan chains: rising tck shifts and captures, falling tck updates
   always @(posedge clk)
   begin
      if (srst)
      begin
         ir_q <= `SCID_OP_IDCODE;
         ir_sh_q <= `SCID_IR_CAPTURE;
         byp_q <= 1'b0;
         id_sh_q <= ID_VALUE;
         bcr_q <= `SCID_BCR_RESET;
         bsr_q <= `SCID_BSR_RESET;
         bsr_upd_q <= `SCID_BSR_RESET;
         tdo_q <= 1'b0;
         tdo_oe_q <= 1'b0;
      end
      else if (tck_rise)
      begin
         case (state)
            `SCID_ST_RESET:
            begin
               ir_q <= `SCID_OP_IDCODE;
               bsr_q <= `SCID_BSR_RESET;
               bsr_upd_q <= `SCID_BSR_RESET;
            end
            `SCID_ST_CAP_IR: ir_sh_q <= `SCID_IR_CAPTURE;
            `SCID_ST_SHIFT_IR: ir_sh_q <= {tdi_s_q, ir_sh_q[`SCID_IR_W-1:1]};
            `SCID_ST_CAP_DR:
            begin
               byp_q <= 1'b0;
               if (sel == `SCID_DR_ID)
                  id_sh_q <= ID_VALUE;
               if (sel == `SCID_DR_BSR)
               begin
                  case (ir_q)
                     `SCID_OP_EXTEST, `SCID_OP_INTEST, `SCID_OP_SAMPLE:
                        bsr_q <= sense_s_q;
                     `SCID_OP_CELL_CHK: bsr_q <= ~bsr_upd_q;
                     default: bsr_q <= bsr_q;
                  endcase
               end
               // control register keeps its value at capture
            end
            `SCID_ST_SHIFT_DR:
            begin
               case (sel)
                  `SCID_DR_BSR: bsr_q <= {tdi_s_q, bsr_q[`SCID_BSR_W-1:1]};
                  `SCID_DR_ID: id_sh_q <= {tdi_s_q, id_sh_q[`SCID_ID_W-1:1]};
                  `SCID_DR_BCR: bcr_q <= {tdi_s_q, bcr_q[`SCID_BCR_W-1:1]};
                  default: byp_q <= tdi_s_q;
               endcase
            end
            `SCID_ST_IDLE:
            begin
               if (tog_only)
                  bsr_q <= bsr_q ^ out_mask;
               else if (run_toggle)
                  bsr_q <= (sense_s_q & in_mask) | ((bsr_q ^ out_mask) & out_mask);
            end
            default: ir_sh_q <= ir_sh_q;
         endcase
      end
      else if (tck_fall)
      begin
         tdo_q <= (state == `SCID_ST_SHIFT_IR) ? ir_sh_q[0] : dr_out;
         tdo_oe_q <= (state == `SCID_ST_SHIFT_IR) || (state == `SCID_ST_SHIFT_DR);
         if (state == `SCID_ST_UPD_IR)
            ir_q <= ir_sh_q;
         if ((state == `SCID_ST_UPD_DR) && (sel == `SCID_DR_BSR))
            bsr_upd_q <= bsr_q;
         // toggle-only refreshes the output shadows alone, so input shadows hold
         if (in_idle && tog_only)
            bsr_upd_q <= (bsr_upd_q & in_mask) | (bsr_q & out_mask);
         if (in_idle && run_toggle)
            bsr_upd_q <= bsr_q;
      end
   end

   // mode and drive outputs, registered from the current instruction, the shadows and the control bits
   always @(posedge clk)
   begin
      if (srst)
      begin
         bnd_drive_q <= `SCID_BSR_RESET;
         test_mode_q <= 1'b0;
         highz_q <= 1'b0;
         bnd_drive_en_q <= 1'b0;
         dr_sel_q <= `SCID_DR_ID;
         run_active_q <= 1'b0;
         run_op_q <= 3'h0;
      end
      else
      begin
         bnd_drive_q <= bsr_upd_q;
         test_mode_q <= (mode != `SCID_MODE_NORMAL);
         highz_q <= (mode == `SCID_MODE_MOD_TEST);
         bnd_drive_en_q <= (mode == `SCID_MODE_TEST);
         dr_sel_q <= sel;
         run_active_q <= (ir_q == `SCID_OP_RUN_BOUNDARY_TEST) && in_idle;
         if ((bcr_op == `SCID_RUN_PSA_PRPG18) || (bcr_op == `SCID_RUN_PSA_COUNT18))
            run_op_q <= bcr_op;
         else
            run_op_q <= {1'b0, bcr_op[1:0]};
      end
   end
endmodule
`default_nettype wire
